/* dv/reset_idle_powerdown_ctrl_tb.sv */
// self-checking testbench for the reset, idle and power-down controller
`timescale 1ns/1ns
module reset_idle_powerdown_ctrl_tb;
  import rip_pkg::*;
  localparam int O_CPU = 0;
  localparam int O_OSC = 1;
  localparam int O_RST = 2;
  localparam int O_LOAD = 3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] irq_en = 2'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, cpu_en, per_en, osc_en, dsm, ram_blk;
  logic int_rst, pc_load, pin, irq, irq0_n, irq1_n, adc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] vec;
  wire logic [3:0] obs = {pc_load, int_rst, osc_en, cpu_en};
  int num_errors = 0;
  int total_checks = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  rip_partner p_u (.ref_clk_i(clk), .rst_pin_o(pin), .irq_req_o(irq), .ext_irq_zero_n_o(irq0_n),
    .ext_irq_one_n_o(irq1_n), .adc_done_o(adc));

  rip_ctrl dut_u (.ref_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .rst_pin_i(pin), .ext_irq_zero_n_i(irq0_n),
    .ext_irq_one_n_i(irq1_n), .irq_req_i(irq), .ext_irq_en_i(irq_en), .adc_done_i(adc),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_en_o(osc_en),
    .double_speed_mode_o(dsm), .ram_block_o(ram_blk), .int_reset_o(int_rst),
    .pc_load_o(pc_load), .pc_vector_o(vec));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid === 1'b1));
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(er));
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid === 1'b1));
    rready <= 1'b0;
    check("rdata", rdata, ed);
    check("rresp", 32'(rresp), 32'(er));
  endtask

  task automatic wait_sig(input int b, input logic v);
    int n = 0;
    while (obs[b] !== v && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("awaited output", 32'(obs[b]), 32'(v));
  endtask

  // pin exit from idle (mode 1) or power-down (mode 3)
  task automatic pin_exit(input logic [31:0] mode);
    wr(OFS_POWER_CONTROL_REG, mode, RESP_OKAY);
    p_u.set_pin(1'b1);
    #1;
    check("cpu clock", 32'(cpu_en), 32'h0000_0001);
    check("oscillator", 32'(osc_en), 32'h0000_0001);
    @(posedge clk);
    #1;
    check("ram block", 32'(ram_blk), 32'h0000_0001);
    wait_sig(O_RST, 1'b1);
    check("ram block", 32'(ram_blk), 32'h0000_0000);
    p_u.set_pin(1'b0);
    wait_sig(O_LOAD, 1'b1);
    check("vector", 32'(vec), 32'(RESET_VECTOR));
    rd(OFS_POWER_CONTROL_REG, 32'h0000_0000, RESP_OKAY);
    $display("test pin exit mode %0d done", mode);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #(20000 * CLK_PERIOD_NS);
    num_errors++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    irq_en <= 2'h1;
    rd(OFS_POWER_CONTROL_REG, 32'h0000_0000, RESP_OKAY);
    rd(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    wr(4'hc, 32'h0000_0001, RESP_SLVERR);
    rd(4'hc, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    check("double speed", 32'(dsm), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'he;
    wr(OFS_POWER_CONTROL_REG, 32'h0000_0001, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_POWER_CONTROL_REG, 32'h0000_0000, RESP_OKAY);
    check("cpu clock", 32'(cpu_en), 32'h0000_0001);
    $display("test registers done");
    wr(OFS_POWER_CONTROL_REG, 32'h0000_000d, RESP_OKAY);
    check("cpu clock", 32'(cpu_en), 32'h0000_0000);
    check("peripheral clock", 32'(per_en), 32'h0000_0001);
    rd(OFS_POWER_CONTROL_REG, 32'h0000_000d, RESP_OKAY);
    rd(OFS_STAT, 32'h0000_0001, RESP_OKAY);
    p_u.set_irq(1'b1);
    wait_sig(O_CPU, 1'b1);
    p_u.set_irq(1'b0);
    rd(OFS_POWER_CONTROL_REG, 32'h0000_000c, RESP_OKAY);
    $display("test idle done");
    wr(OFS_POWER_CONTROL_REG, 32'h0000_0003, RESP_OKAY);
    check("oscillator", 32'(osc_en), 32'h0000_0000);
    check("peripheral clock", 32'(per_en), 32'h0000_0000);
    rd(OFS_POWER_CONTROL_REG, 32'h0000_0002, RESP_OKAY);
    p_u.set_pins(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    check("oscillator", 32'(osc_en), 32'h0000_0000);
    p_u.set_pins(1'b0, 1'b1);
    wait_sig(O_OSC, 1'b1);
    check("cpu clock", 32'(cpu_en), 32'h0000_0000);
    p_u.set_pins(1'b1, 1'b1);
    wait_sig(O_CPU, 1'b1);
    rd(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    irq_en <= 2'h2;
    wr(OFS_POWER_CONTROL_REG, 32'h0000_0002, RESP_OKAY);
    p_u.set_pins(1'b1, 1'b0);
    wait_sig(O_OSC, 1'b1);
    p_u.set_pins(1'b1, 1'b1);
    wait_sig(O_CPU, 1'b1);
    $display("test power-down done");
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(OFS_POWER_CONTROL_REG, 32'h0000_0001, RESP_OKAY);
    p_u.set_adc(1'b1);
    p_u.set_adc(1'b0);
    wait_sig(O_CPU, 1'b1);
    $display("test converter idle done");
    pin_exit(32'h0000_0001);
    pin_exit(32'h0000_0003);
    summarize();
  end
endmodule

/* dv/rip_partner.sv */
// behavioural model of the converter, interrupt logic and external reset pin
`timescale 1ns/1ns
module rip_partner (
  // clock
  input wire logic ref_clk_i,
  // towards the controller
  output logic rst_pin_o,
  output logic irq_req_o,
  output logic ext_irq_zero_n_o,
  output logic ext_irq_one_n_o,
  output logic adc_done_o
);
  int unsigned hold_cnt = 0;

  initial {rst_pin_o, irq_req_o, ext_irq_zero_n_o, ext_irq_one_n_o, adc_done_o} = 5'h06;

  // counts how long the pin has been high
  always_ff @(posedge ref_clk_i)
    hold_cnt <= rst_pin_o ? hold_cnt + 1 : 0;

  task automatic set_pin(input logic v);
    while (!v && rst_pin_o && hold_cnt < rip_pkg::RST_MIN_CLKS) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    rst_pin_o <= v;
  endtask

  task automatic set_irq(input logic v);
    @(posedge ref_clk_i);
    irq_req_o <= v;
  endtask

  task automatic set_pins(input logic z_n, input logic o_n);
    @(posedge ref_clk_i);
    ext_irq_zero_n_o <= z_n;
    ext_irq_one_n_o <= o_n;
  endtask

  // only a conversion end after idle entry; no port write follows idle entry
  task automatic set_adc(input logic v);
    @(posedge ref_clk_i);
    adc_done_o <= v;
  endtask
endmodule

/* hdl/rip_ctrl.sv */
// reset, idle and power-down controller with axi4-lite registers
//
// Behaviour
// - idle stops cpu clock, peripherals run
// - idle keeps pc, psw, sfrs, ram
// - writing idle bit enters idle
// - idle-setting write is last executed
// - both bits set gives power-down only
// - enabled interrupt clears idle, restarts cpu
// - after isr, resume after idling instruction
// - user flags survive idle
// - reset pin clears idle bit asynchronously
// - pin exit runs briefly, then vectors 0000h
// - ram blocked, ports open before reset
// - converter completion ends converter idle
// - power-down stops oscillator and clocks
// - power-down keeps sfrs and ram
// - writing power-down bit enters power-down
// - power-down bit 1, cleared by reset
// - idle bit 0, cleared by interrupt/reset
// - level ext irq wakes, resumes on release
// - reset pin clears power-down asynchronously
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module rip_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // axi4-lite write
  input wire logic [rip_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [rip_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // pins
  input wire logic rst_pin_i,
  input wire logic ext_irq_zero_n_i,
  input wire logic ext_irq_one_n_i,
  // interrupt logic and converter
  input wire logic irq_req_i,
  input wire logic [1:0] ext_irq_en_i,
  input wire logic adc_done_i,
  // clock and reset control
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic double_speed_mode_o,
  output logic ram_block_o,
  output logic int_reset_o,
  output logic pc_load_o,
  output logic [15:0] pc_vector_o
);
  import rip_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rip_state_t state;
  rip_state_t next_state;
  logic pin_s;
  logic [1:0] irq_n_s;
  logic [MC_CNT_W-1:0] mc_cnt;
  logic tick;
  logic [1:0] samp;
  logic rst_seen;
  logic power_control_reg_clr;
  logic idle_request_bit;
  logic powerdown_request_bit;
  logic user_flag_zero;
  logic user_flag_one;
  logic adc_idle_mode;
  logic wake_hw;
  logic [1:0] ctrl;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do;
  logic power_control_reg_wr;
  logic idle_wake;
  logic pd_wake;
  logic pd_release;
  logic [31:0] rd_word;
  logic rd_ok;
  logic pinx_old;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  rip_sync #(.W(3), .INIT(3'h3)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({rst_pin_i, ext_irq_one_n_i, ext_irq_zero_n_i}),
    .q_o({pin_s, irq_n_s})
  );

  // ----------------------------------------------------------------
  // machine cycle and reset pin sampling
  // ----------------------------------------------------------------
  assign tick = (mc_cnt == MC_LAST);

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      mc_cnt <= '0;
    else if (tick)
      mc_cnt <= '0;
    else
      mc_cnt <= mc_cnt + 1'b1;
  end

  // one sample per machine cycle, so a pulse of the minimum width is seen twice
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      samp <= 2'h0;
    else if (tick)
      samp <= {samp[0], pin_s};
  end

  assign rst_seen = (samp == 2'b11);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_got && !s_axi_bvalid_o;
  assign wr_do = aw_got && w_got && !s_axi_bvalid_o;
  assign power_control_reg_wr = wr_do && (aw_addr == OFS_POWER_CONTROL_REG) && w_strb[0];

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_do)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if (aw_addr == OFS_POWER_CONTROL_REG || aw_addr == OFS_CTRL)
          s_axi_bresp_o <= RESP_OKAY;
        else
          s_axi_bresp_o <= RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power control register: request bits
  // ----------------------------------------------------------------
  // the reset pin clears both request bits without the clock
  assign power_control_reg_clr = rst_i || rst_pin_i;
  assign idle_wake = irq_req_i || (adc_idle_mode && adc_done_i);
  assign pd_wake = |(ext_irq_en_i & ~irq_n_s);
  assign pd_release = !(|(ext_irq_en_i & ~irq_n_s));

  always_ff @(posedge ref_clk_i or posedge power_control_reg_clr)
  begin
    if (power_control_reg_clr)
    begin
      idle_request_bit <= 1'b0;
      powerdown_request_bit <= 1'b0;
      adc_idle_mode <= 1'b0;
      wake_hw <= 1'b0;
    end
    else if (state == RIP_RSEQ)
    begin
      idle_request_bit <= 1'b0;
      powerdown_request_bit <= 1'b0;
      adc_idle_mode <= 1'b0;
      wake_hw <= 1'b0;
    end
    else if (power_control_reg_wr)
    begin
      // power-down wins; idle is not remembered for after the wake
      powerdown_request_bit <= w_data[POWER_CONTROL_REG_PD_BIT];
      idle_request_bit <= w_data[POWER_CONTROL_REG_IDLE_BIT] && !w_data[POWER_CONTROL_REG_PD_BIT];
      adc_idle_mode <= ctrl[CTRL_ADC_IDLE_BIT];
      wake_hw <= 1'b0;
    end
    else
    begin
      if (idle_request_bit && idle_wake)
      begin
        idle_request_bit <= 1'b0;
        wake_hw <= 1'b1;
      end
      if (powerdown_request_bit && pd_wake)
      begin
        powerdown_request_bit <= 1'b0;
        wake_hw <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power control register: user flags and control register
  // ----------------------------------------------------------------
  // flags change only on software writes, rst_i or internal reset, never on idle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {user_flag_one, user_flag_zero} <= UFLAG_RST;
      ctrl <= CTRL_RST;
    end
    else if (state == RIP_RSEQ)
    begin
      {user_flag_one, user_flag_zero} <= UFLAG_RST;
      ctrl <= CTRL_RST;
    end
    else if (wr_do && w_strb[0])
    begin
      if (aw_addr == OFS_POWER_CONTROL_REG)
      begin
        user_flag_zero <= w_data[POWER_CONTROL_REG_UF0_BIT];
        user_flag_one <= w_data[POWER_CONTROL_REG_UF1_BIT];
      end
      if (aw_addr == OFS_CTRL)
      begin
        ctrl[CTRL_ADC_IDLE_BIT] <= w_data[CTRL_ADC_IDLE_BIT];
        ctrl[CTRL_X2_BIT] <= w_data[CTRL_X2_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_i)
      OFS_POWER_CONTROL_REG:
      begin
        rd_word[POWER_CONTROL_REG_IDLE_BIT] = idle_request_bit;
        rd_word[POWER_CONTROL_REG_PD_BIT] = powerdown_request_bit;
        rd_word[POWER_CONTROL_REG_UF0_BIT] = user_flag_zero;
        rd_word[POWER_CONTROL_REG_UF1_BIT] = user_flag_one;
      end
      OFS_CTRL:
        rd_word[1:0] = ctrl;
      OFS_STAT:
        rd_word[4:0] = {int_reset_o, pin_s, state};
      default:
        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      RIP_RUN:
        if (rst_seen)
          next_state = RIP_RSEQ;
        else if (powerdown_request_bit)
          next_state = RIP_PDN;
        else if (idle_request_bit)
          next_state = RIP_IDLE;
      RIP_IDLE:
        if (rst_seen)
          next_state = RIP_RSEQ;
        else if (!idle_request_bit)
          next_state = wake_hw ? RIP_RUN : RIP_PINX;
      RIP_PDN:
        if (rst_seen)
          next_state = RIP_RSEQ;
        else if (!powerdown_request_bit)
          next_state = wake_hw ? RIP_WAKE : RIP_PINX;
      RIP_WAKE:
        if (rst_seen)
          next_state = RIP_RSEQ;
        else if (pd_release)
          next_state = RIP_RUN;
      RIP_PINX:
        if (rst_seen)
          next_state = RIP_RSEQ;
        else if (tick && samp == 2'b00 && !pin_s && pinx_old)
          next_state = RIP_RUN;
      RIP_RSEQ:
        if (samp == 2'b00)
          next_state = RIP_RUN;
      default:
        next_state = RIP_RSEQ;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state <= RIP_RUN;
    else
      state <= next_state;
  end

  // the synchronised pin lags pin-exit entry; stale low samples must not end it
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pinx_old <= 1'b0;
    else
      pinx_old <= (state == RIP_PINX);
  end

  // vector load on leaving the internal reset
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_load_o <= 1'b0;
      pc_vector_o <= RESET_VECTOR;
    end
    else
    begin
      pc_load_o <= (state == RIP_RSEQ) && (next_state == RIP_RUN);
      pc_vector_o <= RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // clock, reset and access control outputs
  // ----------------------------------------------------------------
  // cpu clock stops the cycle after the request write, freezing pc and psw
  // after an irq wake from power-down the cpu stays stopped until the pin is released
  assign cpu_clk_en_o = !idle_request_bit && !powerdown_request_bit
    && (state != RIP_WAKE) && !(state == RIP_PDN && wake_hw);
  assign periph_clk_en_o = !powerdown_request_bit;
  assign osc_en_o = !powerdown_request_bit;
  assign double_speed_mode_o = ctrl[CTRL_X2_BIT];
  assign ram_block_o = (state == RIP_PINX);
  assign int_reset_o = (state == RIP_RSEQ);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_IDLE_CLOCKS: assert property (idle_request_bit |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("idle clocks wrong");
  AST_IDLE_ENTRY: assert property (power_control_reg_wr && w_data[POWER_CONTROL_REG_IDLE_BIT] && !w_data[POWER_CONTROL_REG_PD_BIT]
    && !pin_s |=> idle_request_bit ##0 !cpu_clk_en_o)
    else $error("idle write did not stop cpu");
  AST_BOTH_PDOWN: assert property (power_control_reg_wr && w_data[POWER_CONTROL_REG_IDLE_BIT] && w_data[POWER_CONTROL_REG_PD_BIT]
    && !rst_pin_i |=> powerdown_request_bit && !idle_request_bit)
    else $error("double request did not give power-down only");
  AST_IRQ_WAKE: assert property (idle_request_bit && irq_req_i && !power_control_reg_wr
    && state != RIP_RSEQ |=> !idle_request_bit ##0 cpu_clk_en_o)
    else $error("interrupt did not end idle");
  AST_FLAGS_KEEP: assert property (idle_request_bit && state != RIP_RSEQ
    |=> $stable({user_flag_one, user_flag_zero}))
    else $error("user flags changed in idle");
  AST_PIN_CLEARS: assert property (rst_pin_i |-> !idle_request_bit && !powerdown_request_bit)
    else $error("reset pin did not clear requests");
  AST_ADC_WAKE: assert property (idle_request_bit && adc_idle_mode && adc_done_i && !power_control_reg_wr
    && state != RIP_RSEQ |=> !idle_request_bit)
    else $error("conversion did not end idle");
  AST_PD_STOP: assert property (powerdown_request_bit |-> !osc_en_o && !periph_clk_en_o
    && !cpu_clk_en_o)
    else $error("power-down clocks wrong");
  AST_PD_WAIT: assert property (state == RIP_WAKE && !pd_release && !rst_seen
    |=> state == RIP_WAKE ##0 osc_en_o && !cpu_clk_en_o)
    else $error("resumed before irq release");
  AST_RAM_BLOCK: assert property (state == RIP_PINX |-> ram_block_o && cpu_clk_en_o)
    else $error("ram open during pin exit");
  AST_TWO_SAMPLES: assert property ($rose(rst_seen) |=> int_reset_o [*2])
    else $error("reset sequence not started");
  AST_VECTOR: assert property ($fell(int_reset_o) |-> pc_load_o && pc_vector_o == RESET_VECTOR)
    else $error("no vector load after reset");

  COV_IDLE_IRQ: cover property (state == RIP_IDLE ##1 state == RIP_RUN);
  COV_PD_WAKE: cover property (state == RIP_PDN ##1 state == RIP_WAKE ##[1:200] state == RIP_RUN);
  COV_PIN_EXIT: cover property (state == RIP_PINX ##[1:40] state == RIP_RSEQ);
endmodule

/* hdl/rip_pkg.sv */
// shared constants and types for the reset, idle and power-down controller
package rip_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MC_OSC_CLKS = 12;
  localparam int unsigned RST_MIN_MC = 2;
  localparam int unsigned RST_MIN_CLKS = RST_MIN_MC * MC_OSC_CLKS;
  localparam int unsigned MC_CNT_W = 4;
  localparam logic [MC_CNT_W-1:0] MC_LAST = MC_CNT_W'(MC_OSC_CLKS - 1);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_POWER_CONTROL_REG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;

  localparam int unsigned POWER_CONTROL_REG_IDLE_BIT = 0;
  localparam int unsigned POWER_CONTROL_REG_PD_BIT = 1;
  localparam int unsigned POWER_CONTROL_REG_UF0_BIT = 2;
  localparam int unsigned POWER_CONTROL_REG_UF1_BIT = 3;
  localparam int unsigned CTRL_ADC_IDLE_BIT = 0;
  localparam int unsigned CTRL_X2_BIT = 1;

  localparam logic [1:0] UFLAG_RST = 2'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RIP_RUN  = 3'b000,
    RIP_IDLE = 3'b001,
    RIP_PDN  = 3'b010,
    RIP_WAKE = 3'b011,
    RIP_PINX = 3'b100,
    RIP_RSEQ = 3'b101
  } rip_state_t;
endpackage

/* hdl/rip_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module rip_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= INIT;
      q_o <= INIT;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
